// ==== design/fgc_pkg.sv ====
// Package for the gauge command register bank: offsets, reset values, I2C constants.
// Assumes one 250 MHz clock domain; no outside dependencies.
package fgc_pkg;
   localparam logic [7:0] CMD_RSVD_A = 8'h00;
   localparam logic [7:0] CMD_RSVD_B = 8'h01;
   localparam logic [7:0] CMD_MIN_EMPTY = 8'h03;
   localparam logic [7:0] CMD_REINIT_SAMPLE = 8'h04;
   localparam logic [7:0] CMD_MIN_FULL = 8'h05;
   localparam logic [7:0] CMD_CELL_BETA = 8'h06;
   localparam logic [7:0] CMD_REINIT_NOW = 8'h07;
   localparam logic [7:0] CMD_CELL_TEMP = 8'h08;
   localparam logic [7:0] CMD_CELL_VOLT = 8'h09;
   localparam logic [7:0] CMD_CHG_DIR = 8'h0A;
   localparam logic [7:0] CMD_PACK_ADJ = 8'h0B;
   localparam logic [7:0] CMD_THERM_DLY = 8'h0C;
   localparam logic [7:0] CMD_CHG_PCT = 8'h0D;
   localparam logic [7:0] CMD_AMB_BETA = 8'h0E;
   localparam logic [7:0] CMD_FINE_CHG = 8'h0F;
   localparam logic [7:0] CMD_VERSION = 8'h11;
   localparam logic [7:0] CMD_PROFILE_SEL = 8'h12;
   localparam logic [7:0] CMD_LOW_CHG_ALM = 8'h13;
   localparam logic [7:0] CMD_LOW_VOLT_ALM = 8'h14;
   localparam logic [7:0] CMD_PWR_MODE = 8'h15;
   localparam logic [7:0] CMD_THERM_EN = 8'h16;
   localparam logic [7:0] CMD_CYCLES = 8'h17;
   localparam logic [7:0] CMD_BATT_STATE = 8'h19;
   localparam logic [7:0] CMD_PROFILE_CODE = 8'h1A;

   localparam logic [15:0] RST_MIN_EMPTY = 16'hFFFF;
   localparam logic [15:0] RST_MIN_FULL = 16'hFFFF;
   localparam logic [15:0] RST_BETA = 16'h0D34;
   localparam logic [15:0] RST_CELL_TEMP = 16'h0BA6;
   localparam logic [15:0] RST_THERM_DLY = 16'h001E;
   localparam logic [15:0] RST_PWR_MODE = 16'h0002;
   localparam logic [15:0] RST_BATT_STATE = 16'h00C0;
   localparam logic [15:0] RST_ZERO = 16'h0000;

   localparam logic [15:0] KEY_SAMPLE1 = 16'hAA55;
   localparam logic [15:0] KEY_SAMPLE4 = 16'hAA58;
   localparam logic [15:0] KEY_REINIT = 16'hAA55;

   localparam logic [15:0] PCT_MAX = 16'h0064;
   localparam logic [15:0] FINE_MAX = 16'h03E8;
   localparam logic [15:0] THERM_EN_MASK = 16'h0003;

   localparam logic [6:0] I2C_ADDR = 7'h0B;
   localparam logic [7:0] CRC_POLY = 8'h07;

   localparam int CLK_MHZ = 250;
   localparam int REINIT_TIME_US_X10 = 15;
   // Longest time, exact with no rounding: 1.5 ms at 250 MHz
   localparam int REINIT_CYC = (REINIT_TIME_US_X10 * CLK_MHZ * 100);

   typedef struct packed {
      logic [15:0] volt;
      logic [15:0] pct;
      logic [15:0] fine;
      logic [15:0] min_empty;
      logic [15:0] min_full;
      logic [15:0] cycles;
   } fgc_meas_s;
endpackage : fgc_pkg

// ==== design/fgc_regs.sv ====
// Gauge command register bank behind an I2C target with CRC-8 protected words.
// Assumes scl/sda pins from outside, estimator values from same-clock logic.
// Function
// - Read-only minutes-to-empty word, resets to all ones.
// - Read-only minutes-to-full word, resets to all ones.
// - Sample command AA55..AA58 re-derives charge from stored sample one to four.
// - Initialise command AA55 re-derives charge from stored sample one, as sample command AA55 does.
// - Cell temperature in 0.1 K, reset 0x0BA6, host may write it.
// - Thermistor delay adjust word, read/write, resets to 0x001E.
// - Charge percent 0 to 100, read/write.
// - Read-only fine charge indicator, 0 to 1000 tenths.
// - Two thermistor beta words, read/write, reset 0x0D34.
// - Low charge alarm level, zero disables, reset zero.
// - Low voltage alarm level in mV, zero disables, reset zero.
// - Thermistor enable bits zero and one, reset zero.
// - Battery state word read/write, resets to 0x00C0.
// - Read-only version word.
// - I2C target at address 0001011, bytes 0x16 and 0x17.
// - Written words without correct CRC-8 are discarded.
// - Target never stretches SCL; host still waits for it.
// - Charge re-initialisation completes within 1.5 ms.
`timescale 1ns/1ps
`default_nettype none
module fgc_regs #(
   parameter logic [15:0] VERSION_CODE = 16'h1234, // Arbitrary value
   parameter logic [15:0] PROFILE_CODE = 16'h0001, // Arbitrary value
   parameter int REINIT_CYC = fgc_pkg::REINIT_CYC
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire fgc_pkg::fgc_meas_s i_meas,
   input wire logic [15:0] i_reinit_pct,
   input wire logic i_meas_valid,
   output logic o_scl_oe,
   output logic o_sda_oe,
   output logic o_sda_o,
   output logic [1:0] o_reinit_src,
   output logic o_reinit_req,
   output logic [15:0] o_cell_beta,
   output logic [15:0] o_amb_beta,
   output logic [15:0] o_cell_temp,
   output logic [15:0] o_chg_dir,
   output logic [15:0] o_pack_adj,
   output logic [15:0] o_therm_dly,
   output logic [15:0] o_profile_sel,
   output logic [15:0] o_low_chg_alm,
   output logic [15:0] o_low_volt_alm,
   output logic [15:0] o_pwr_mode,
   output logic [1:0] o_therm_en,
   output logic [15:0] o_batt_state,
   output logic [15:0] o_chg_pct
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TXACK = 3'b100,
      ST_SKIP = 3'b101
   } fgc_st_e;

   // Pins cross in through two flops before any use
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_d;
   logic sda_d;
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], i_scl};
         sda_sync <= {sda_sync[0], i_sda};
         scl_d <= scl_sync[1];
         sda_d <= sda_sync[1];
      end
   end
   wire scl_s = scl_sync[1];
   wire sda_s = sda_sync[1];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c = scl_s & scl_d & ~sda_d & sda_s;

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ fgc_pkg::CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : crc8

   fgc_st_e st;
   logic [2:0] bit_cnt;
   logic [7:0] shreg;
   logic [2:0] byte_idx;
   logic is_read;
   logic [7:0] cmd;
   logic [7:0] crc;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [7:0] tx_byte;
   logic rx_armed;
   logic wr_commit;
   logic [15:0] rd_word;
   logic [15:0] minutes_to_empty;
   logic [15:0] minutes_to_full;
   logic [15:0] cell_thermistor_beta;
   logic [15:0] ambient_thermistor_beta;
   logic [15:0] cell_temperature;
   logic [15:0] cell_voltage;
   logic [15:0] charge_direction;
   logic [15:0] pack_adjust_param;
   logic [15:0] thermistor_delay_adjust;
   logic [15:0] charge_percent;
   logic [15:0] fine_charge_indicator;
   logic [15:0] profile_select;
   logic [15:0] low_charge_alarm_level;
   logic [15:0] low_voltage_alarm_level;
   logic [15:0] power_mode_select;
   logic [1:0] thermistor_enable_bits;
   logic [15:0] cycle_counter;
   logic [15:0] battery_state_word;
   logic [31:0] reinit_timer;

   always_comb begin
      rd_word = 16'h0000;
      case (cmd)
         fgc_pkg::CMD_MIN_EMPTY: rd_word = minutes_to_empty;
         fgc_pkg::CMD_MIN_FULL: rd_word = minutes_to_full;
         fgc_pkg::CMD_CELL_BETA: rd_word = cell_thermistor_beta;
         fgc_pkg::CMD_CELL_TEMP: rd_word = cell_temperature;
         fgc_pkg::CMD_CELL_VOLT: rd_word = cell_voltage;
         fgc_pkg::CMD_CHG_DIR: rd_word = charge_direction;
         fgc_pkg::CMD_PACK_ADJ: rd_word = pack_adjust_param;
         fgc_pkg::CMD_THERM_DLY: rd_word = thermistor_delay_adjust;
         fgc_pkg::CMD_CHG_PCT: rd_word = charge_percent;
         fgc_pkg::CMD_AMB_BETA: rd_word = ambient_thermistor_beta;
         fgc_pkg::CMD_FINE_CHG: rd_word = fine_charge_indicator;
         fgc_pkg::CMD_VERSION: rd_word = VERSION_CODE;
         fgc_pkg::CMD_PROFILE_SEL: rd_word = profile_select;
         fgc_pkg::CMD_LOW_CHG_ALM: rd_word = low_charge_alarm_level;
         fgc_pkg::CMD_LOW_VOLT_ALM: rd_word = low_voltage_alarm_level;
         fgc_pkg::CMD_PWR_MODE: rd_word = power_mode_select;
         fgc_pkg::CMD_THERM_EN: rd_word = {14'h0, thermistor_enable_bits};
         fgc_pkg::CMD_CYCLES: rd_word = cycle_counter;
         fgc_pkg::CMD_BATT_STATE: rd_word = battery_state_word;
         fgc_pkg::CMD_PROFILE_CODE: rd_word = PROFILE_CODE;
         default: rd_word = 16'h0000;
      endcase
   end

   always_comb begin
      case (byte_idx)
         3'd2: tx_byte = rdata[7:0];
         3'd3: tx_byte = rdata[15:8];
         default: tx_byte = crc;
      endcase
   end

   // byte engine; write bytes: addr, cmd, lo, hi, crc
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st <= ST_IDLE;
         bit_cnt <= 3'd0;
         shreg <= 8'h00;
         byte_idx <= 3'd0;
         is_read <= 1'b0;
         cmd <= 8'h00;
         crc <= 8'h00;
         wdata <= 16'h0000;
         rdata <= 16'h0000;
         rx_armed <= 1'b0;
         wr_commit <= 1'b0;
         o_sda_oe <= 1'b0;
         o_sda_o <= 1'b0;
      end else begin
         wr_commit <= 1'b0;
         if (start_c) begin
            st <= ST_RX;
            bit_cnt <= 3'd0;
            rx_armed <= 1'b0;
            byte_idx <= 3'd0;
            o_sda_oe <= 1'b0;
            // Repeated start keeps the running CRC only after the command byte of a write; any other start clears it
            if (byte_idx != 3'd2 || is_read) begin
               crc <= 8'h00;
            end
         end else if (stop_c) begin
            st <= ST_IDLE;
            o_sda_oe <= 1'b0;
         end else begin
            case (st)
               ST_IDLE: o_sda_oe <= 1'b0;
               ST_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + 3'd1;
                     rx_armed <= 1'b1;
                  end
                  // The clock fall of a start condition carries no bit and must not end a byte
                  if (scl_fall && bit_cnt == 3'd0 && rx_armed) begin
                     rx_armed <= 1'b0;
                     st <= ST_ACK;
                     o_sda_oe <= 1'b1;
                     crc <= crc8(crc, shreg);
                     if (byte_idx == 3'd0) begin
                        is_read <= shreg[0];
                        if (shreg[7:1] != fgc_pkg::I2C_ADDR) begin
                           o_sda_oe <= 1'b0;
                           st <= ST_SKIP;
                        end
                     end else if (byte_idx == 3'd1) begin
                        cmd <= shreg;
                     end else if (byte_idx == 3'd2) begin
                        wdata[7:0] <= shreg;
                     end else if (byte_idx == 3'd3) begin
                        wdata[15:8] <= shreg;
                     end else if (byte_idx == 3'd4) begin
                        wr_commit <= (shreg == crc);
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     o_sda_oe <= 1'b0;
                     byte_idx <= byte_idx + 3'd1;
                     if (byte_idx == 3'd0 && is_read) begin
                        byte_idx <= 3'd2;
                        rdata <= rd_word;
                        st <= ST_TX;
                        o_sda_oe <= ~rd_word[7];
                        bit_cnt <= 3'd1;
                     end else begin
                        st <= (byte_idx >= 3'd4) ? ST_SKIP : ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     bit_cnt <= bit_cnt + 3'd1;
                     if (bit_cnt == 3'd0) begin
                        o_sda_oe <= 1'b0;
                        crc <= crc8(crc, tx_byte);
                        st <= ST_TXACK;
                     end else begin
                        o_sda_oe <= ~tx_byte[3'd7 - bit_cnt];
                     end
                  end
               end
               ST_TXACK: begin
                  if (scl_rise && sda_s) begin
                     st <= ST_SKIP;
                  end else if (scl_fall) begin
                     byte_idx <= byte_idx + 3'd1;
                     st <= (byte_idx >= 3'd4) ? ST_SKIP : ST_TX;
                     o_sda_oe <= ~((byte_idx == 3'd2) ? rdata[15] : crc[7]);
                     bit_cnt <= 3'd1;
                  end
               end
               ST_SKIP: o_sda_oe <= 1'b0;
               default: st <= ST_IDLE;
            endcase
         end
      end
   end

   // never stretches: every byte answers in time
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_scl_oe <= 1'b0;
      end else begin
         o_scl_oe <= 1'b0;
      end
   end

   wire wr_cmd = wr_commit;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         minutes_to_empty <= fgc_pkg::RST_MIN_EMPTY;
         minutes_to_full <= fgc_pkg::RST_MIN_FULL;
         fine_charge_indicator <= fgc_pkg::RST_ZERO;
         cell_voltage <= fgc_pkg::RST_ZERO;
         cycle_counter <= fgc_pkg::RST_ZERO;
      end else if (i_meas_valid) begin
         minutes_to_empty <= i_meas.min_empty;
         minutes_to_full <= i_meas.min_full;
         fine_charge_indicator <= (i_meas.fine > fgc_pkg::FINE_MAX) ? fgc_pkg::FINE_MAX : i_meas.fine;
         cell_voltage <= i_meas.volt;
         cycle_counter <= i_meas.cycles;
      end
   end

   // re-init request, answer awaited at most REINIT_CYC
   // The estimator keeps the power-up samples; only the sample index leaves here
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_reinit_req <= 1'b0;
         o_reinit_src <= 2'd0;
         reinit_timer <= 32'd0;
      end else begin
         o_reinit_req <= 1'b0;
         if (reinit_timer != 32'd0) begin
            reinit_timer <= reinit_timer - 32'd1;
         end
         if (wr_cmd && cmd == fgc_pkg::CMD_REINIT_SAMPLE && wdata >= fgc_pkg::KEY_SAMPLE1
             && wdata <= fgc_pkg::KEY_SAMPLE4) begin
            o_reinit_req <= 1'b1;
            o_reinit_src <= 2'(wdata - fgc_pkg::KEY_SAMPLE1);
            reinit_timer <= 32'(REINIT_CYC);
         end else if (wr_cmd && cmd == fgc_pkg::CMD_REINIT_NOW && wdata == fgc_pkg::KEY_REINIT) begin
            o_reinit_req <= 1'b1;
            o_reinit_src <= 2'd0;
            reinit_timer <= 32'(REINIT_CYC);
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cell_thermistor_beta <= fgc_pkg::RST_BETA;
         ambient_thermistor_beta <= fgc_pkg::RST_BETA;
         cell_temperature <= fgc_pkg::RST_CELL_TEMP;
         charge_direction <= fgc_pkg::RST_ZERO;
         pack_adjust_param <= fgc_pkg::RST_ZERO;
         thermistor_delay_adjust <= fgc_pkg::RST_THERM_DLY;
         profile_select <= fgc_pkg::RST_ZERO;
         low_charge_alarm_level <= fgc_pkg::RST_ZERO;
         low_voltage_alarm_level <= fgc_pkg::RST_ZERO;
         power_mode_select <= fgc_pkg::RST_PWR_MODE;
         thermistor_enable_bits <= 2'b00;
         battery_state_word <= fgc_pkg::RST_BATT_STATE;
      end else if (wr_cmd) begin
         case (cmd)
            fgc_pkg::CMD_CELL_BETA: cell_thermistor_beta <= wdata;
            fgc_pkg::CMD_AMB_BETA: ambient_thermistor_beta <= wdata;
            fgc_pkg::CMD_CELL_TEMP: cell_temperature <= wdata;
            fgc_pkg::CMD_CHG_DIR: charge_direction <= wdata;
            fgc_pkg::CMD_PACK_ADJ: pack_adjust_param <= wdata;
            fgc_pkg::CMD_THERM_DLY: thermistor_delay_adjust <= wdata;
            fgc_pkg::CMD_PROFILE_SEL: profile_select <= wdata;
            fgc_pkg::CMD_LOW_CHG_ALM: low_charge_alarm_level <= wdata;
            fgc_pkg::CMD_LOW_VOLT_ALM: low_voltage_alarm_level <= wdata;
            fgc_pkg::CMD_PWR_MODE: power_mode_select <= wdata;
            fgc_pkg::CMD_THERM_EN: thermistor_enable_bits <= wdata[1:0];
            fgc_pkg::CMD_BATT_STATE: battery_state_word <= wdata;
            default: ;
         endcase
      end
   end

   // charge percent: host write, or re-init result, clamped to 100
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         charge_percent <= fgc_pkg::RST_ZERO;
      end else if (wr_cmd && cmd == fgc_pkg::CMD_CHG_PCT) begin
         charge_percent <= (wdata > fgc_pkg::PCT_MAX) ? fgc_pkg::PCT_MAX : wdata;
      end else if (i_meas_valid) begin
         charge_percent <= (i_reinit_pct > fgc_pkg::PCT_MAX) ? fgc_pkg::PCT_MAX : i_reinit_pct;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_cell_beta <= fgc_pkg::RST_BETA;
         o_amb_beta <= fgc_pkg::RST_BETA;
         o_cell_temp <= fgc_pkg::RST_CELL_TEMP;
         o_chg_dir <= fgc_pkg::RST_ZERO;
         o_pack_adj <= fgc_pkg::RST_ZERO;
         o_therm_dly <= fgc_pkg::RST_THERM_DLY;
         o_profile_sel <= fgc_pkg::RST_ZERO;
         o_low_chg_alm <= fgc_pkg::RST_ZERO;
         o_low_volt_alm <= fgc_pkg::RST_ZERO;
         o_pwr_mode <= fgc_pkg::RST_PWR_MODE;
         o_therm_en <= 2'b00;
         o_batt_state <= fgc_pkg::RST_BATT_STATE;
         o_chg_pct <= fgc_pkg::RST_ZERO;
      end else begin
         o_cell_beta <= cell_thermistor_beta;
         o_amb_beta <= ambient_thermistor_beta;
         o_cell_temp <= cell_temperature;
         o_chg_dir <= charge_direction;
         o_pack_adj <= pack_adjust_param;
         o_therm_dly <= thermistor_delay_adjust;
         o_profile_sel <= profile_select;
         o_low_chg_alm <= low_charge_alarm_level;
         o_low_volt_alm <= low_voltage_alarm_level;
         o_pwr_mode <= power_mode_select;
         o_therm_en <= thermistor_enable_bits;
         o_batt_state <= battery_state_word;
         o_chg_pct <= charge_percent;
      end
   end
endmodule : fgc_regs
`default_nettype wire

// ==== dv/fgc_regs_asserts.sv ====
// Port checker for the gauge command register bank.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fgc_regs_asserts (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_scl_oe,
   input wire logic o_sda_oe,
   input wire logic o_reinit_req,
   input wire logic [15:0] o_cell_beta,
   input wire logic [15:0] o_amb_beta,
   input wire logic [15:0] o_cell_temp,
   input wire logic [15:0] o_therm_dly,
   input wire logic [15:0] o_low_chg_alm,
   input wire logic [15:0] o_low_volt_alm,
   input wire logic [1:0] o_therm_en,
   input wire logic [15:0] o_batt_state,
   input wire logic [15:0] o_chg_pct
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   chk_reset_temp: assert property ($rose(i_rst_n) |-> o_cell_temp == 16'h0BA6)
      else $error("cell temperature not at reset value");
   chk_reset_beta: assert property ($rose(i_rst_n) |-> o_cell_beta == 16'h0D34 && o_amb_beta == 16'h0D34)
      else $error("beta words not at reset value");
   chk_reset_misc: assert property ($rose(i_rst_n) |-> o_therm_dly == 16'h001E
      && o_low_chg_alm == 16'h0000 && o_low_volt_alm == 16'h0000 && o_therm_en == 2'h0 && o_batt_state == 16'h00C0)
      else $error("control words not at reset value");
   chk_req_one_cycle: assert property (o_reinit_req |=> !o_reinit_req)
      else $error("re-init request longer than one cycle");
   // Data may only move while the clock line is low, else it forms a start or stop
   chk_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data line changed with clock high");
   chk_stop_release: assert property (i_scl && $rose(i_sda) |-> !o_sda_oe [*8])
      else $error("data line driven after stop");
   chk_no_stretch: assert property (!o_scl_oe)
      else $error("clock line pulled low");
   chk_pct_range: assert property (o_chg_pct <= 16'h0064)
      else $error("charge percent above range");
   cov_req: cover property (o_reinit_req);
   cov_stop: cover property (i_scl && $rose(i_sda));
   cov_ack: cover property ($rose(o_sda_oe));
endmodule : fgc_regs_asserts
bind fgc_regs fgc_regs_asserts u_chk (.i_mclk, .i_rst_n, .i_scl, .i_sda, .o_scl_oe, .o_sda_oe, .o_reinit_req,
   .o_cell_beta, .o_amb_beta, .o_cell_temp, .o_therm_dly, .o_low_chg_alm, .o_low_volt_alm, .o_therm_en,
   .o_batt_state, .o_chg_pct);
`default_nettype wire

// ==== dv/fgc_host_model.sv ====
// Behavioural I2C host controller with CRC-8 word transfers.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module fgc_host_model #(
   parameter int Q = 100
) (
   input wire logic i_mclk,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_low,
   output logic o_sda_low
);
   logic [7:0] crc;
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   // Quarter bit of 100 cycles: above the pin rating, but the target needs only a few cycles per phase
   task automatic qw();
      repeat (Q) @(negedge i_mclk);
   endtask : qw
   task automatic scl_up();
      o_scl_low = 1'b0;
      for (int n = 0; n < 4000 && i_scl !== 1'b1; n++) @(negedge i_mclk);
   endtask : scl_up
   function automatic logic [7:0] crc_next(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
      return r;
   endfunction : crc_next
   task automatic clk_bit(input logic b, output logic s);
      o_sda_low = !b;
      qw();
      scl_up();
      qw();
      s = i_sda;
      qw();
      o_scl_low = 1'b1;
      qw();
   endtask : clk_bit
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(tx[i], s);
         rx[i] = s;
      end
   endtask : xfer
   task automatic start();
      o_sda_low = 1'b0;
      qw();
      scl_up();
      qw();
      o_sda_low = 1'b1;
      qw();
      o_scl_low = 1'b1;
      qw();
   endtask : start
   task automatic stop();
      o_sda_low = 1'b1;
      qw();
      scl_up();
      qw();
      o_sda_low = 1'b0;
      qw();
   endtask : stop
   task automatic wbyte(input logic [7:0] v, inout logic nak);
      logic [7:0] r;
      logic a;
      xfer(v, r);
      crc = crc_next(crc, v);
      clk_bit(1'b1, a);
      nak = nak | a;
   endtask : wbyte
   // low byte first, CRC over all
   task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, input logic [7:0] flip, output logic nak);
      nak = 1'b0;
      crc = 8'h00;
      start();
      wbyte(8'h16, nak);
      wbyte(cmd, nak);
      wbyte(d[7:0], nak);
      wbyte(d[15:8], nak);
      wbyte(crc ^ flip, nak);
      stop();
   endtask : wr_word
   task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok, output logic nak);
      logic [7:0] c;
      logic a;
      nak = 1'b0;
      crc = 8'h00;
      start();
      wbyte(8'h16, nak);
      wbyte(cmd, nak);
      start();
      wbyte(8'h17, nak);
      xfer(8'hFF, d[7:0]);
      clk_bit(1'b0, a);
      xfer(8'hFF, d[15:8]);
      clk_bit(1'b0, a);
      xfer(8'hFF, c);
      clk_bit(1'b1, a);
      ok = (c === crc_next(crc_next(crc, d[7:0]), d[15:8]));
      stop();
   endtask : rd_word
endmodule : fgc_host_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the gauge command register bank.
// Assumes estimator inputs idle; host model drives the I2C lines.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rst_n, scl_low, sda_low, scl_oe, sda_oe, sda_o, req, nak, ok;
   logic scl_w, sda_w;
   logic [1:0] src, src_seen, ten;
   logic [15:0] temp, beta, dly, alm_c, alm_v, batt, pwr, d;
   logic [15:0] amb, dir, padj, psel, pct;
   int fail_count, check_count, req_seen;
   assign scl_w = !(scl_low || scl_oe);
   assign sda_w = !(sda_low || (sda_oe && !sda_o));
   fgc_regs dut (.i_mclk(clk), .i_rst_n(rst_n), .i_scl(scl_w), .i_sda(sda_w), .i_meas('0),
      .i_reinit_pct(16'h0000), .i_meas_valid(1'b0), .o_scl_oe(scl_oe), .o_sda_oe(sda_oe), .o_sda_o(sda_o),
      .o_reinit_src(src), .o_reinit_req(req), .o_cell_beta(beta), .o_amb_beta(amb), .o_cell_temp(temp),
      .o_chg_dir(dir), .o_pack_adj(padj), .o_therm_dly(dly), .o_profile_sel(psel), .o_low_chg_alm(alm_c),
      .o_low_volt_alm(alm_v), .o_pwr_mode(pwr), .o_therm_en(ten), .o_batt_state(batt), .o_chg_pct(pct));
   fgc_host_model host (.i_mclk(clk), .i_scl(scl_w), .i_sda(sda_w), .o_scl_low(scl_low), .o_sda_low(sda_low));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (req === 1'b1) begin
         req_seen <= req_seen + 1;
         src_seen <= src;
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic t_reset();
      check("cell_temp", temp, 16'h0BA6);
      check("therm_dly", dly, 16'h001E);
      check("cell_beta", beta, 16'h0D34);
      check("low_chg_alm", alm_c, 16'h0000);
      check("low_volt_alm", alm_v, 16'h0000);
      check("therm_en", {14'h0, ten}, 16'h0000);
      check("batt_state", batt, 16'h00C0);
      check("pwr_mode", pwr, 16'h0002);
      check("amb_beta", amb, 16'h0D34);
      check("chg_dir", dir, 16'h0000);
      check("pack_adj", padj, 16'h0000);
      check("profile_sel", psel, 16'h0000);
      check("chg_pct", pct, 16'h0000);
   endtask : t_reset
   // Zero degrees is a boundary value that differs from reset
   task automatic t_write_temp();
      host.wr_word(fgc_pkg::CMD_CELL_TEMP, 16'h0AAC, 8'h00, nak);
      repeat (4) @(negedge clk);
      check("write_ack", {15'h0, nak}, 16'h0000);
      check("cell_temp", temp, 16'h0AAC);
   endtask : t_write_temp
   task automatic t_bad_crc();
      host.wr_word(fgc_pkg::CMD_CELL_TEMP, 16'h0DCC, 8'h01, nak);
      repeat (4) @(negedge clk);
      check("cell_temp_kept", temp, 16'h0AAC);
   endtask : t_bad_crc
   task automatic t_reinit();
      host.wr_word(fgc_pkg::CMD_REINIT_SAMPLE, 16'hAA57, 8'h00, nak);
      repeat (4) @(negedge clk);
      check("reinit_count", 16'(req_seen), 16'h0001);
      check("reinit_src", {14'h0, src_seen}, 16'h0002);
   endtask : t_reinit
   task automatic t_read();
      host.rd_word(fgc_pkg::CMD_MIN_EMPTY, d, ok, nak);
      check("min_empty", d, 16'hFFFF);
      check("read_crc", {15'h0, ok}, 16'h0001);
      check("read_ack", {15'h0, nak}, 16'h0000);
   endtask : t_read
   initial begin
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_write_temp();
      t_bad_crc();
      t_reinit();
      t_read();
      end_of_test();
   end
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      $display("ERROR watchdog expected done seen hang");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
